// ==== hdl/msfr_buf2.sv ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides run on the system clock; outputs come from flops.
*/
`timescale 1ns/1ps
module msfr_buf2 #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_i,   // System clock
  input  wire logic         rst_n_i,     // Asynchronous reset, active low
  input  wire logic         in_valid_i,  // Word offered
  input  wire logic [W-1:0] in_data_i,   // Offered word
  output logic              in_ready_o,  // Room for a word
  output logic              out_valid_o, // Head word valid
  output logic [W-1:0]      out_data_o,  // Head word
  input  wire logic         out_ready_i  // Head word taken
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic         hv;  // Head valid
    logic [W-1:0] hd;  // Head word
    logic         tv;  // Tail valid
    logic [W-1:0] td;  // Tail word
  } msfr_buf_t;

  msfr_buf_t r;
  msfr_buf_t next_r;

  // Pop moves the tail forward, push fills the first free slot
  always_comb begin
    next_r = r;
    if (r.hv && out_ready_i) begin
      if (r.tv) begin
        next_r.hd = r.td;
        next_r.tv = 1'b0;
      end else begin
        next_r.hv = 1'b0;
      end
    end
    if (in_valid_i && !r.tv) begin
      if (!next_r.hv) begin
        next_r.hv = 1'b1;
        next_r.hd = in_data_i;
      end else begin
        next_r.tv = 1'b1;
        next_r.td = in_data_i;
      end
    end
  end

  // Register the state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready_o  = !r.tv;
  assign out_valid_o = r.hv;
  assign out_data_o  = r.hd;

endmodule

// ==== hdl/msfr_pkg.sv ====
/*
  Shared constants and types of the memory mapped serial flash reader.
  Assumes a 100 MHz system clock and one 24-bit addressed flash device.
*/
package msfr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned SYS_CLK_HZ  = 100_000_000; // System clock rate
  localparam int unsigned SCK_BOOT_HZ = 4_000_000;   // Serial clock after reset
  localparam int unsigned SCK_MAX_HZ  = 25_000_000;  // Fastest allowed serial clock

  // Half period in system cycles, rounded up so the boot clock stays below 4 MHz
  localparam logic [7:0] DIV_RESET = 8'((SYS_CLK_HZ + 2 * SCK_BOOT_HZ - 1) / (2 * SCK_BOOT_HZ));
  // Smallest half period that leaves room for the input synchroniser
  localparam logic [7:0] DIV_MIN   = 8'h04;
  localparam logic [3:0] GAP_RESET = 4'hf;           // Widest select gap
  localparam logic       FAST_RESET = 1'b0;          // Normal read after reset

  ////////////////////////////////////////////////////////////////////////
  // Serial commands and frame lengths
  localparam logic [7:0] CMD_READ  = 8'h03;          // Normal read
  localparam logic [7:0] CMD_FAST  = 8'h0b;          // Fast read, one dummy byte
  localparam logic [7:0] DUMMY     = 8'h00;          // Dummy byte value
  localparam logic [5:0] TX_NORMAL = 6'h20;          // Command and address bits
  localparam logic [5:0] TX_FAST   = 6'h28;          // Plus the dummy byte
  localparam logic [5:0] RX_BITS   = 6'h20;          // One data word

  ////////////////////////////////////////////////////////////////////////
  // Boot and masters
  localparam logic [1:0]  STRAP_AUTO_BOOT = 2'h0;    // Strap code for flash boot
  localparam logic [31:0] BOOT_ADDR       = 32'h0000_0000; // First fetch address
  localparam int          NUM_MASTERS     = 2;       // Embedded and external CPU

  // Serial engine states
  typedef enum logic [2:0] {
    MSFR_IDLE,
    MSFR_TX,
    MSFR_RX,
    MSFR_HOLD,
    MSFR_GAP
  } msfr_state_t;

endpackage

// ==== hdl/msfr_reader.sv ====
/*
  Memory mapped serial flash reader with shared bus arbiter, prefetch,
  programmable timing and manual pin control.
  Assumes masters hold a request until acknowledged and keep one read
  outstanding; the flash works in clock mode 0 with 24-bit addresses.
*/
`timescale 1ns/1ps
module msfr_reader #(
  parameter int NM = msfr_pkg::NUM_MASTERS,
  parameter int IW = $clog2(NM)
) (
  input  wire logic                 sys_clk_i,                       // System clock
  input  wire logic                 rst_n_i,                         // Reset, active low
  input  wire logic [NM-1:0]        bus_req_i,                       // Read request
  input  wire logic [NM-1:0][31:0]  bus_addr_i,                      // Byte address
  input  wire logic [NM-1:0]        bus_last_i,                      // Last beat of burst
  output logic      [NM-1:0]        bus_ack_o,                       // Request taken
  output logic      [NM-1:0]        bus_grant_o,                     // Bus owner
  output logic                      bus_rvalid_o,                    // Read word valid
  output logic      [31:0]          bus_rdata_o,                     // Read word
  input  wire logic                 bus_rready_i,                    // Owner takes word
  input  wire logic [IW-1:0]        master_priority_level_one_i,     // First choice
  input  wire logic [IW-1:0]        master_priority_level_two_i,     // Second choice
  input  wire logic [IW-1:0]        master_priority_level_three_i,   // Third choice
  input  wire logic                 flash_master_timing_config_wr_i, // Timing write
  input  wire logic [7:0]           cfg_clock_div_i,                 // Half period
  input  wire logic                 quick_read_enable_i,             // Fast command
  input  wire logic [3:0]           select_gap_time_i,               // Gap periods
  input  wire logic [1:0]           boot_strap_select_i,             // Boot strap
  output logic                      cpu_boot_enable_o,               // CPU boots flash
  output logic      [31:0]          cpu_boot_addr_o,                 // Boot address
  input  wire logic                 manual_pin_override_enable_i,    // Manual mode
  input  wire logic                 manual_pin_control_sel_i,        // Select value
  input  wire logic                 manual_pin_control_sel_oe_i,     // Select enable
  input  wire logic                 manual_pin_control_clk_i,        // Clock value
  input  wire logic                 manual_pin_control_clk_oe_i,     // Clock enable
  input  wire logic                 manual_pin_control_dout_i,       // Data value
  input  wire logic                 manual_pin_control_dout_oe_i,    // Data enable
  output logic                      sampled_flash_input_level_o,     // Data-in level
  output logic                      flash_select_n_o,                // Chip select
  output logic                      flash_select_oe_o,               // Select enable
  output logic                      flash_clk_o,                     // Serial clock
  output logic                      flash_clk_oe_o,                  // Clock enable
  output logic                      flash_mosi_o,                    // Data out
  output logic                      flash_mosi_oe_o,                 // Data enable
  input  wire logic                 flash_master_in_i                // Data in pin
);
  import msfr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic              gv;      // Grant valid
    logic [IW-1:0]     gi;      // Granted master
    logic [NM-1:0]     gvec;    // Grant vector
    logic              burst;   // Burst still open
    logic              rwait;   // Answer outstanding
    logic [NM-1:0]     ack;     // Take pulse
    msfr_state_t       st;      // Engine state
    logic [7:0]        div;     // Configured half period
    logic [3:0]        gap;     // Configured gap
    logic              fast;    // Configured fast read
    logic [7:0]        ldiv;    // Half period of frame
    logic [3:0]        lgap;    // Gap of frame
    logic [12:0]       cnt;     // Half period or gap count
    logic              sck;     // Engine clock
    logic              csn;     // Engine select
    logic              mosi;    // Engine data out
    logic [39:0]       tx;      // Outgoing bits
    logic [5:0]        bits;    // Bits left
    logic [31:0]       rx;      // Incoming bits
    logic [21:0]       waddr;   // Word on the link
    logic              wv;      // Word wanted
    logic [21:0]       wa;      // Wanted word
    logic              pv;      // Push pending
    logic [31:0]       pd;      // Push word
    logic [2:0]        sy;      // Input synchroniser
    logic              mi;      // Filtered data in
    logic              boot_en; // Master mode
    logic              seen;    // Strap caught
    logic              sel_n;   // Pin select
    logic              sel_oe;  // Pin select enable
    logic              clk;     // Pin clock
    logic              clk_oe;  // Pin clock enable
    logic              dout;    // Pin data
    logic              dout_oe; // Pin data enable
  } msfr_regs_t;

  msfr_regs_t r;
  msfr_regs_t next_r;

  logic          buf_in_ready; // Room in buffer
  logic [IW:0]   win;          // Found flag and winner
  logic          take;         // Request accepted
  logic          tick;         // Half period elapsed
  logic [7:0]    cmd;          // Command of new frame
  logic [12:0]   gapc;         // Gap length in cycles

  ////////////////////////////////////////////////////////////////////////
  // Winner from three levels, then lowest index
  function automatic logic [IW:0] pick(input logic [NM-1:0] req, input logic [IW-1:0] l1,
                                       input logic [IW-1:0] l2, input logic [IW-1:0] l3);
    logic [IW:0] res;
    res = '0;
    for (int i = NM - 1; i >= 0; i--) begin
      if (req[i]) begin
        res = {1'b1, IW'(i)};
      end
    end
    if (req[l3]) begin
      res = {1'b1, l3};
    end
    if (req[l2]) begin
      res = {1'b1, l2};
    end
    if (req[l1]) begin
      res = {1'b1, l1};
    end
    return res;
  endfunction

  // Bus side byte lanes: flash byte n of the word in lane n
  function automatic logic [31:0] lanes(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r = r;
    cmd    = r.fast ? CMD_FAST : CMD_READ;
    gapc   = 13'(r.lgap * r.ldiv * 13'h2);
    tick   = (r.cnt == {5'h00, r.ldiv - 8'h01});
    win    = pick(bus_req_i, master_priority_level_one_i, master_priority_level_two_i,
                  master_priority_level_three_i);
    take   = r.gv && bus_req_i[r.gi] && !r.rwait && !r.wv;
    next_r.ack = '0;
    // Buffer takes the pending word
    if (r.pv && buf_in_ready) begin
      next_r.pv = 1'b0;
    end
    // Three-stage data-in synchroniser with agreement filter
    next_r.sy = {r.sy[1:0], flash_master_in_i};
    if (r.sy[1] == r.sy[2]) begin
      next_r.mi = r.sy[2];
    end
    // Timing write; frames use latched copies
    if (flash_master_timing_config_wr_i) begin
      next_r.div  = cfg_clock_div_i;
      next_r.gap  = select_gap_time_i;
      next_r.fast = quick_read_enable_i;
    end
    // Strap caught once after reset release
    next_r.seen = 1'b1;
    if (!r.seen) begin
      next_r.boot_en = (boot_strap_select_i == STRAP_AUTO_BOOT);
    end
    // Arbitration only between transfers
    if (!r.gv && win[IW]) begin
      next_r.gv = 1'b1;
      next_r.gi = win[IW-1:0];
    end
    // Take a read request from the owner
    if (take) begin
      next_r.ack[r.gi] = 1'b1;
      next_r.wv        = 1'b1;
      next_r.wa        = bus_addr_i[r.gi][23:2];
      next_r.rwait     = 1'b1;
      next_r.burst     = !bus_last_i[r.gi];
    end
    // Answer taken; release unless a burst goes on
    if (bus_rvalid_o && bus_rready_i) begin
      next_r.rwait = 1'b0;
      if (!r.burst) begin
        next_r.gv = 1'b0;
      end
    end
    next_r.gvec = '0;
    if (next_r.gv) begin
      next_r.gvec[next_r.gi] = 1'b1;
    end
    // Serial engine
    case (r.st)
      MSFR_IDLE: begin
        // New frame with latched timing
        if (r.wv && !manual_pin_override_enable_i) begin
          next_r.ldiv  = (r.div < DIV_MIN) ? DIV_MIN : r.div;
          next_r.lgap  = r.gap;
          next_r.tx    = {cmd, r.wa, 2'b00, DUMMY};
          next_r.bits  = r.fast ? TX_FAST : TX_NORMAL;
          next_r.waddr = r.wa;
          next_r.csn   = 1'b0;
          next_r.mosi  = cmd[7];
          next_r.sck   = 1'b0;
          next_r.cnt   = '0;
          next_r.st    = MSFR_TX;
        end
      end
      MSFR_TX: begin
        // Shift out on falling edges
        if (tick) begin
          next_r.cnt = '0;
          next_r.sck = !r.sck;
          if (r.sck) begin
            next_r.tx   = {r.tx[38:0], 1'b0};
            next_r.mosi = r.tx[38];
            next_r.bits = r.bits - 6'h01;
            if (r.bits == 6'h01) begin
              next_r.mosi = 1'b0;
              next_r.bits = RX_BITS;
              next_r.st   = MSFR_RX;
            end
          end
        end else begin
          next_r.cnt = r.cnt + 13'h1;
        end
      end
      MSFR_RX: begin
        // Sample on falling edges, one full period after launch
        if (tick) begin
          next_r.cnt = '0;
          next_r.sck = !r.sck;
          if (r.sck) begin
            next_r.rx   = {r.rx[30:0], r.mi};
            next_r.bits = r.bits - 6'h01;
            if (r.bits == 6'h01) begin
              next_r.st = MSFR_HOLD;
            end
          end
        end else begin
          next_r.cnt = r.cnt + 13'h1;
        end
      end
      MSFR_HOLD: begin
        // Word ready, clock parked low
        if (manual_pin_override_enable_i) begin
          next_r.csn = 1'b1;
          next_r.cnt = gapc;
          next_r.st  = MSFR_GAP;
        end else if (r.wv && r.wa == r.waddr && !next_r.pv) begin
          next_r.pv    = 1'b1;
          next_r.pd    = lanes(r.rx);
          next_r.wv    = 1'b0;
          next_r.waddr = r.waddr + 22'h1;
          next_r.bits  = RX_BITS;
          next_r.cnt   = '0;
          next_r.st    = MSFR_RX;
        end else if (r.wv && r.wa != r.waddr) begin
          next_r.csn = 1'b1;
          next_r.cnt = gapc;
          next_r.st  = MSFR_GAP;
        end
      end
      MSFR_GAP: begin
        // Select high for the gap; the idle cycle after it completes the count
        if (r.cnt <= 13'h2) begin
          next_r.st = MSFR_IDLE;
        end else begin
          next_r.cnt = r.cnt - 13'h1;
        end
      end
      default: begin
        next_r.st = MSFR_IDLE;
      end
    endcase
    // Pin stage: manual values or engine in master mode
    if (manual_pin_override_enable_i) begin
      next_r.sel_n   = manual_pin_control_sel_i;
      next_r.sel_oe  = manual_pin_control_sel_oe_i;
      next_r.clk     = manual_pin_control_clk_i;
      next_r.clk_oe  = manual_pin_control_clk_oe_i;
      next_r.dout    = manual_pin_control_dout_i;
      next_r.dout_oe = manual_pin_control_dout_oe_i;
    end else begin
      next_r.sel_n   = next_r.csn;
      next_r.clk     = next_r.sck;
      next_r.dout    = next_r.mosi;
      next_r.sel_oe  = r.boot_en;
      next_r.clk_oe  = r.boot_en;
      next_r.dout_oe = r.boot_en;
    end
  end

  // Register the state; timing defaults are the boot values
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r       <= '0;
      r.div   <= DIV_RESET;
      r.gap   <= GAP_RESET;
      r.fast  <= FAST_RESET;
      r.ldiv  <= DIV_RESET;
      r.csn   <= 1'b1;
      r.sel_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer buffer between engine and bus
  msfr_buf2 #(
    .W (32)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (r.pv),
    .in_data_i   (r.pd),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (bus_rvalid_o),
    .out_data_o  (bus_rdata_o),
    .out_ready_i (bus_rready_i)
  );

  assign bus_ack_o                   = r.ack;
  assign bus_grant_o                 = r.gvec;
  assign cpu_boot_enable_o           = r.boot_en;
  assign cpu_boot_addr_o             = BOOT_ADDR;
  assign sampled_flash_input_level_o = r.mi;
  assign flash_select_n_o            = r.sel_n;
  assign flash_select_oe_o           = r.sel_oe;
  assign flash_clk_o                 = r.clk;
  assign flash_clk_oe_o              = r.clk_oe;
  assign flash_mosi_o                = r.dout;
  assign flash_mosi_oe_o             = r.dout_oe;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ack_grant;
    r.ack != '0 |-> r.gv && r.ack == (NM'(1) << r.gi);
  endproperty
  a_ack_grant: assert property (p_ack_grant) else $error("ack to non-owner");

  property p_burst_hold;
    r.gv && r.burst |=> r.gv && r.gi == $past(r.gi);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("grant lost in burst");

  property p_prio;
    !r.gv && bus_req_i[master_priority_level_one_i]
      |=> r.gv && r.gi == $past(master_priority_level_one_i);
  endproperty
  a_prio: assert property (p_prio) else $error("priority ignored");

  property p_cmd;
    r.st == MSFR_IDLE ##1 r.st == MSFR_TX
      |-> r.tx[39:32] == ($past(r.fast) ? CMD_FAST : CMD_READ)
          && r.bits == ($past(r.fast) ? TX_FAST : TX_NORMAL);
  endproperty
  a_cmd: assert property (p_cmd) else $error("wrong command");

  property p_addr;
    r.st == MSFR_IDLE ##1 r.st == MSFR_TX |-> r.tx[31:8] == {r.waddr, 2'b00} && !r.csn;
  endproperty
  a_addr: assert property (p_addr) else $error("wrong flash address");

  property p_idle_clk;
    r.csn |-> !r.sck;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock while deselected");

  property p_gap;
    r.st == MSFR_GAP && r.cnt > 13'h2 |=> r.st == MSFR_GAP && r.csn && r.cnt == $past(r.cnt) - 13'h1;
  endproperty
  a_gap: assert property (p_gap) else $error("gap cut short");

  property p_prefetch;
    r.st == MSFR_HOLD && !manual_pin_override_enable_i && r.wv && r.wa == r.waddr
      && (!r.pv || buf_in_ready) |=> r.st == MSFR_RX && r.pv && r.waddr == $past(r.waddr) + 22'h1;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("no prefetch");

  property p_latch;
    (r.st == MSFR_TX || r.st == MSFR_RX) && $past(r.st) != MSFR_IDLE |-> $stable(r.ldiv);
  endproperty
  a_latch: assert property (p_latch) else $error("timing changed in frame");

  property p_manual;
    manual_pin_override_enable_i
      |=> flash_select_n_o == $past(manual_pin_control_sel_i)
          && flash_clk_oe_o == $past(manual_pin_control_clk_oe_i);
  endproperty
  a_manual: assert property (p_manual) else $error("manual pins ignored");

  property p_master;
    r.boot_en && !manual_pin_override_enable_i |=> flash_select_oe_o && flash_clk_oe_o && flash_mosi_oe_o;
  endproperty
  a_master: assert property (p_master) else $error("master mode not forced");

endmodule

// ==== tb/msfr_flash_model.sv ====
/* Serial flash model answering read and fast read.
   Assumes clock mode 0 and a pulled-up select line. */
`timescale 1ns/1ps
module msfr_flash_model (
  input  wire logic sel_n_i, // Chip select
  input  wire logic sck_i,   // Serial clock
  input  wire logic mosi_i,  // Data from master
  output logic      miso_o   // Data to master
);
  import msfr_pkg::*;
  logic [7:0]  cmd;  // Last command byte
  logic [39:0] sh;   // Incoming bits
  logic [23:0] ptr;  // Byte pointer
  logic [7:0]  b;    // Byte being sent
  int          cnt;  // Bits taken in
  int          bi;   // Bit of byte sent
  int          tx;   // Header length
  initial miso_o = 1'b0;
  // Released line shows the inverse of its last value
  always @(posedge sel_n_i) miso_o = ~miso_o;
  // New frame
  always @(negedge sel_n_i) begin
    cnt = 0;
    bi = 0;
    tx = 40;
  end
  // Command, address and dummy taken MSB first
  always @(posedge sck_i) if (!sel_n_i && cnt < tx) begin
    sh = {sh[38:0], mosi_i};
    cnt++;
    if (cnt == 8) cmd = sh[7:0];
    if (cnt == 8) tx = (cmd == CMD_FAST) ? 40 : 32;
    if (cnt == 32) ptr = sh[23:0];
  end
  // Sequential bytes on falling clock
  always @(negedge sck_i) if (!sel_n_i && cnt >= tx) begin
    b = ptr[7:0] ^ ptr[15:8] ^ 8'h3c;
    miso_o = b[7-bi];
    bi++;
    if (bi == 8) begin
      bi = 0;
      ptr++;
    end
  end
endmodule

// ==== tb/tb.sv ====
/* Bench of the flash reader with a flash model.
   Assumes strap for automatic boot, a pulled-up select pin and pulled-down clock and data pins. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
  import msfr_pkg::*;
  logic clk, rst_n, rready, rvalid, p1, p2, p3, cwr, quick, ben, mo, ms, mso, mc, mco;
  logic md, mdo, smp, sel_n, soe, sck, ckoe, mosi, dmoe, miso;
  logic [1:0] req, last, ack, grant, strap;
  logic [1:0][31:0] addr;
  logic [31:0] rdata, baddr;
  logic [7:0] div;
  logic [3:0] gap;
  int tests_run, bad_count, cyc, hi, gap_len;
  wire cs_w = soe ? sel_n : 1'b1;
  msfr_reader dut (.sys_clk_i(clk), .rst_n_i(rst_n), .bus_req_i(req), .bus_addr_i(addr),
    .bus_last_i(last), .bus_ack_o(ack), .bus_grant_o(grant), .bus_rvalid_o(rvalid),
    .bus_rdata_o(rdata), .bus_rready_i(rready), .master_priority_level_one_i(p1),
    .master_priority_level_two_i(p2), .master_priority_level_three_i(p3),
    .flash_master_timing_config_wr_i(cwr), .cfg_clock_div_i(div), .quick_read_enable_i(quick),
    .select_gap_time_i(gap), .boot_strap_select_i(strap), .cpu_boot_enable_o(ben),
    .cpu_boot_addr_o(baddr), .manual_pin_override_enable_i(mo), .manual_pin_control_sel_i(ms),
    .manual_pin_control_sel_oe_i(mso), .manual_pin_control_clk_i(mc),
    .manual_pin_control_clk_oe_i(mco), .manual_pin_control_dout_i(md),
    .manual_pin_control_dout_oe_i(mdo), .sampled_flash_input_level_o(smp),
    .flash_select_n_o(sel_n), .flash_select_oe_o(soe), .flash_clk_o(sck), .flash_clk_oe_o(ckoe),
    .flash_mosi_o(mosi), .flash_mosi_oe_o(dmoe), .flash_master_in_i(miso));
  msfr_flash_model fl (.sel_n_i(cs_w), .sck_i(ckoe & sck), .mosi_i(dmoe & mosi), .miso_o(miso));
  // Expected word: lane k holds flash byte 4*word+k
  function automatic logic [31:0] wd(logic [23:0] a);
    logic [23:0] q;
    for (int k = 0; k < 4; k++) begin
      q = {a[23:2], 2'b00} + 24'(k);
      wd[8*k+:8] = q[7:0] ^ q[15:8] ^ 8'h3c;
    end
  endfunction
  // Clock and select gap monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (cs_w) hi++;
    else if (hi != 0) begin
      gap_len = hi;
      hi = 0;
    end
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic req_on(int m, logic [31:0] a, logic l);
    @(negedge clk);
    req[m] = 1'b1;
    addr[m] = a;
    last[m] = l;
  endtask
  // Wait for acknowledge, then release request
  task automatic take(int m, logic [1:0] e);
    for (int n = 0; n < 9000 && ack === 2'b00; n++) @(posedge clk) #1;
    `CHK("ack", e, ack)
    @(negedge clk);
    req[m] = 1'b0;
  endtask
  task automatic get(logic [31:0] e, int b);
    for (int n = 0; n < b && !(rvalid === 1'b1 && rready === 1'b1); n++) @(posedge clk) #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
    @(posedge clk) #1;
  endtask
  task automatic t_reset();
    repeat (2) @(negedge clk);
    `CHK("pins", 4'b1101, {sel_n, soe, sck, ben})
    `CHK("boot", BOOT_ADDR, baddr)
  endtask
  task automatic t_single();
    req_on(0, 32'h101, 1'b1);
    take(0, 2'b01);
    get(wd(24'h101), 9000);
    `CHK("cmd", CMD_READ, fl.cmd)
  endtask
  // Burst under stall while the other master waits
  task automatic t_burst();
    @(negedge clk);
    rready = 1'b0;
    {req, addr[1], addr[0], last} = {2'b11, 32'h300, 32'h200, 2'b10};
    take(0, 2'b01);
    for (int n = 0; n < 9000 && rvalid !== 1'b1; n++) @(negedge clk);
    // Stall long enough for the prefetched word to park
    repeat (900) @(negedge clk);
    `CHK("stall", 1'b1, rvalid)
    rready = 1'b1;
    get(wd(24'h200), 5);
    `CHK("grant", 2'b01, grant)
    req_on(0, 32'h204, 1'b1);
    take(0, 2'b01);
    get(wd(24'h204), 20);
    take(1, 2'b10);
    get(wd(24'h300), 9000);
  endtask
  task automatic t_prio();
    @(negedge clk);
    {p1, req, addr[1], addr[0], last} = {3'b111, 32'h400, 32'h500, 2'b11};
    take(1, 2'b10);
    get(wd(24'h400), 9000);
    take(0, 2'b01);
    get(wd(24'h500), 9000);
    @(negedge clk);
    p1 = 1'b0;
  endtask
  task automatic t_fast();
    @(negedge clk);
    {div, quick, gap, cwr} = {8'h04, 1'b1, 4'h1, 1'b1};
    @(negedge clk);
    cwr = 1'b0;
    req_on(0, 32'h40, 1'b1);
    take(0, 2'b01);
    get(wd(24'h40), 9000);
    req_on(0, 32'h80, 1'b1);
    take(0, 2'b01);
    get(wd(24'h80), 9000);
    `CHK("cmd", CMD_FAST, fl.cmd)
    `CHK("gap", 8, gap_len)
  endtask
  task automatic t_manual();
    @(negedge clk);
    {mo, ms, mso, mc, mco, md, mdo} = 7'b1011111;
    repeat (2) @(negedge clk);
    `CHK("manual", 6'b011111, {sel_n, soe, sck, ckoe, mosi, dmoe})
    ms = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("din", miso, smp)
    mo = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_n, req, last, addr, p1, p2, p3, cwr, quick, div, gap, strap} = '0;
    {mo, ms, mso, mc, mco, md, mdo, rready} = 8'h01;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_single();
    t_burst();
    t_prio();
    t_fast();
    t_manual();
    close_out();
  end
endmodule
